// [src/sci_map.vh]
// register indices, field positions and reset values of the serial controller
`ifndef SCI_MAP_VH
`define SCI_MAP_VH
// register indices; byte address is four times the index
`define SCI_IDX_DATA      16'h4490
`define SCI_IDX_MODE      16'h4492
`define SCI_IDX_SPI_STAT  16'h44a0
`define SCI_IDX_I2C_STAT  16'h44a2
`define SCI_IDX_I2C_CMD   16'h44a6
`define SCI_IDX_I2C_ACK   16'h44a8
`define SCI_IDX_SPI_CFG   16'h44ac
`define SCI_IDX_RATE_LIN  16'h44b0
`define SCI_IDX_RATE_EXP  16'h44b2
// spi_config fields
`define SCI_CFG_POL       0
`define SCI_CFG_PHA       1
`define SCI_CFG_LSB       2
`define SCI_CFG_RPT       3
`define SCI_CFG_MST       4
`define SCI_CFG_RXDRV     5
// spi_status fields
`define SCI_SST_OVF       0
`define SCI_SST_RXVAL     1
`define SCI_SST_TXFREE    2
`define SCI_SST_TXIDLE    3
// i2c_command fields
`define SCI_CMD_RECV      0
`define SCI_CMD_SEND      1
`define SCI_CMD_START     2
`define SCI_CMD_STOP      3
// i2c status fields
`define SCI_IST_NACK      0
`define SCI_IST_TXFIN     1
`define SCI_IST_RXFIN     2
`define SCI_IST_CMDFIN    3
// reset values and constants
`define SCI_RST_CFG       6'h00
`define SCI_RST_CMD       4'h0
`define SCI_RST_RATE      4'h0
`define SCI_BUSY_TOKEN    8'hff
`define SCI_SPI_LAST_HALF 5'h0f
`define SCI_I2C_LAST_BIT  4'h8
`define SCI_RESP_OKAY     2'h0
`define SCI_RESP_SLVERR   2'h2
`endif

// [src/sci_serial_ctrl.v]
// spi and i2c master serial controller with axi4-lite register access
// How it works
// - spi master starts on tx data, or on rx room when rx-driven is set
// - on tx underrun send 0xff, or repeat last byte when repeat set
// - repeat setting changes only when tx fifo empty and shifter idle
// - bit order bit selects msb first or lsb first
// - phase bit selects sampling on leading or trailing edge
// - polarity bit selects clock idle low or idle high
// - tx idle flag means tx fifo empty and shifter done
// - tx space flag means tx fifo can take one more byte
// - rx valid flag means rx fifo holds an unread byte
// - overrun set on push into full rx fifo with no data read in that cycle, cleared by data read
// - stop command makes a stop condition, self clears when done
// - start command makes a start or repeated start, self clears
// - send command shifts one byte out, self clears when done
// - receive command clocks one byte in, self clears when done
// - ack control picks ack or nack after each received byte
// - half bit period is (lin+1)*2^exp clock cycles
// - command finished flag set on start or stop done, clears on activity
// - received nack flag set on slave nack, clears on next activity
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "sci_map.vh"
module sci_serial_ctrl #(
  parameter ADDR_W = 20,
  parameter DEPTH  = 4,
  parameter PTR_W  = 2
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg               spi_sck,
  output reg               spi_mosi,
  input  wire              spi_miso,
  input  wire              scl_i,
  output reg               scl_o,
  output reg               scl_oe,
  input  wire              sda_i,
  output reg               sda_o,
  output reg               sda_oe
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_SPI   = 3'h1;
  localparam ST_START = 3'h2;
  localparam ST_STOP  = 3'h3;
  localparam ST_BYTE  = 3'h4;

  reg [ADDR_W-1:0] awaddr_ff;
  reg              aw_have_ff;
  reg [31:0]       wdata_ff;
  reg              w_have_ff;
  reg [5:0]        cfg_ff;
  reg [3:0]        cmd_ff;
  reg              ack_ff;
  reg              mode_i2c_ff;
  reg [3:0]        lin_ff;
  reg [3:0]        exp_ff;
  reg              rpt_act_ff;
  reg              ovf_ff;
  reg [3:0]        ist_ff;
  reg [7:0]        tx_mem [0:DEPTH-1];
  reg [7:0]        rx_mem [0:DEPTH-1];
  reg [PTR_W-1:0]  tx_wp_ff;
  reg [PTR_W-1:0]  tx_rp_ff;
  reg [PTR_W:0]    tx_cnt_ff;
  reg [PTR_W-1:0]  rx_wp_ff;
  reg [PTR_W-1:0]  rx_rp_ff;
  reg [PTR_W:0]    rx_cnt_ff;
  reg [2:0]        st_ff;
  reg [4:0]        ph_ff;
  reg [3:0]        bit_ff;
  reg [19:0]       div_ff;
  reg [7:0]        sh_ff;
  reg [7:0]        rxs_ff;
  reg [7:0]        last_ff;
  reg              i2c_rx_ff;
  reg              rx_push_ff;
  reg [7:0]        rx_byte_ff;
  reg [31:0]       rd_val;
  reg              rd_hit;
  reg [3:0]        cmd_clr;
  reg              wstrb_ok_ff;

  // register decode on word index
  wire [ADDR_W-3:0] w_idx  = awaddr_ff[ADDR_W-1:2];
  wire [ADDR_W-3:0] r_idx  = s_axi_araddr[ADDR_W-1:2];
  wire              wr_do  = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  wire              wr_ok  = wr_do & wstrb_ok_ff;
  wire              rd_do  = s_axi_arvalid & s_axi_arready;
  wire              wr_data = wr_do & (w_idx == `SCI_IDX_DATA);
  wire              rd_data = rd_do & (r_idx == `SCI_IDX_DATA);

  // fifo levels
  wire tx_empty = (tx_cnt_ff == {(PTR_W+1){1'b0}});
  wire tx_full  = (tx_cnt_ff == DEPTH[PTR_W:0]);
  wire rx_empty = (rx_cnt_ff == {(PTR_W+1){1'b0}});
  wire rx_full  = (rx_cnt_ff == DEPTH[PTR_W:0]);
  wire idle     = (st_ff == ST_IDLE);

  // engine launch; the rx-driven mode keeps going on an empty tx fifo
  wire spi_go   = idle & ~mode_i2c_ff & cfg_ff[`SCI_CFG_MST] &
                  (cfg_ff[`SCI_CFG_RXDRV] ? ~rx_full : ~tx_empty);
  wire i2c_go   = idle & mode_i2c_ff & (cmd_ff != `SCI_RST_CMD);
  wire send_go  = i2c_go & ~cmd_ff[`SCI_CMD_STOP] & ~cmd_ff[`SCI_CMD_START] & cmd_ff[`SCI_CMD_SEND];
  wire tx_pop   = (spi_go | send_go) & ~tx_empty;
  wire tx_push  = wr_data & ~tx_full;
  wire rx_pop   = rd_data & ~rx_empty;
  wire [7:0] under_byte = rpt_act_ff ? last_ff : `SCI_BUSY_TOKEN;
  wire [7:0] load_byte  = tx_empty ? under_byte : tx_mem[tx_rp_ff];

  // half bit timer
  wire [19:0] lim  = (({16'h0000, lin_ff} + 20'h00001) << exp_ff) - 20'h00001;
  wire        tick = ~idle & (div_ff == lim);

  wire lsbf   = cfg_ff[`SCI_CFG_LSB];
  wire cpha   = cfg_ff[`SCI_CFG_PHA];
  wire outbit = lsbf ? sh_ff[0] : sh_ff[7];
  wire [7:0] sh_nxt = lsbf ? {1'b0, sh_ff[7:1]} : {sh_ff[6:0], 1'b0};
  wire [7:0] rx_smp = lsbf ? {spi_miso, rxs_ff[7:1]} : {rxs_ff[6:0], spi_miso};
  wire       lead   = ~ph_ff[0];

  // byte enables must cover the low byte for a write to land, except data writes, which ignore them; kept with the data beat
  function wdata_strb_ok;
    input [3:0] strb;
    begin
      wdata_strb_ok = strb[0];
    end
  endfunction

  // axi write channels: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SCI_RESP_OKAY;
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      awaddr_ff     <= {ADDR_W{1'b0}};
      wdata_ff      <= 32'h00000000;
      wstrb_ok_ff   <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_have_ff & ~(s_axi_awvalid & s_axi_awready) & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready  <= ~w_have_ff & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ok_ff <= wdata_strb_ok(s_axi_wstrb);
      end
      if (wr_do)
      begin
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit(w_idx) ? `SCI_RESP_OKAY : `SCI_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  function wr_hit;
    input [ADDR_W-3:0] idx;
    begin
      wr_hit = (idx == `SCI_IDX_DATA) | (idx == `SCI_IDX_MODE) | (idx == `SCI_IDX_SPI_STAT) |
               (idx == `SCI_IDX_I2C_STAT) | (idx == `SCI_IDX_I2C_CMD) | (idx == `SCI_IDX_I2C_ACK) |
               (idx == `SCI_IDX_SPI_CFG) | (idx == `SCI_IDX_RATE_LIN) | (idx == `SCI_IDX_RATE_EXP);
    end
  endfunction

  // read mux; reserved bits stay zero
  always @*
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (r_idx == `SCI_IDX_DATA)
      rd_val[7:0] = rx_empty ? 8'h00 : rx_mem[rx_rp_ff];
    else if (r_idx == `SCI_IDX_MODE)
      rd_val[0] = mode_i2c_ff;
    else if (r_idx == `SCI_IDX_SPI_STAT)
    begin
      rd_val[`SCI_SST_TXIDLE] = tx_empty & (~(st_ff == ST_SPI));
      rd_val[`SCI_SST_TXFREE] = ~tx_full;
      rd_val[`SCI_SST_RXVAL]  = ~rx_empty;
      rd_val[`SCI_SST_OVF]    = ovf_ff;
    end
    else if (r_idx == `SCI_IDX_I2C_STAT)
      rd_val[3:0] = ist_ff;
    else if (r_idx == `SCI_IDX_I2C_CMD)
      rd_val[3:0] = cmd_ff;
    else if (r_idx == `SCI_IDX_I2C_ACK)
      rd_val[0] = ack_ff;
    else if (r_idx == `SCI_IDX_SPI_CFG)
      rd_val[5:0] = cfg_ff;
    else if (r_idx == `SCI_IDX_RATE_LIN)
      rd_val[3:0] = lin_ff;
    else if (r_idx == `SCI_IDX_RATE_EXP)
      rd_val[3:0] = exp_ff;
    else
      rd_hit = 1'b0;
  end

  // axi read channel, answer one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SCI_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_do;
      if (rd_do)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? `SCI_RESP_OKAY : `SCI_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // writable registers; a command written in the cycle it completes is kept
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_ff      <= `SCI_RST_CFG;
      cmd_ff      <= `SCI_RST_CMD;
      ack_ff      <= 1'b0;
      mode_i2c_ff <= 1'b0;
      lin_ff      <= `SCI_RST_RATE;
      exp_ff      <= `SCI_RST_RATE;
      rpt_act_ff  <= 1'b0;
      ovf_ff      <= 1'b0;
    end
    else
    begin
      if (wr_ok & (w_idx == `SCI_IDX_SPI_CFG))
        cfg_ff <= wdata_ff[5:0];
      if (wr_ok & (w_idx == `SCI_IDX_I2C_CMD))
        cmd_ff <= (cmd_ff & ~cmd_clr) | wdata_ff[3:0];
      else
        cmd_ff <= cmd_ff & ~cmd_clr;
      if (wr_ok & (w_idx == `SCI_IDX_I2C_ACK))
        ack_ff <= wdata_ff[0];
      if (wr_ok & (w_idx == `SCI_IDX_MODE))
        mode_i2c_ff <= wdata_ff[0];
      if (wr_ok & (w_idx == `SCI_IDX_RATE_LIN))
        lin_ff <= wdata_ff[3:0];
      if (wr_ok & (w_idx == `SCI_IDX_RATE_EXP))
        exp_ff <= wdata_ff[3:0];
      if (tx_empty & idle)
        rpt_act_ff <= cfg_ff[`SCI_CFG_RPT];
      if (rx_push_ff & rx_full & ~rx_pop)
        ovf_ff <= 1'b1;
      else if (rd_data)
        ovf_ff <= 1'b0;
    end
  end

  // fifos; a push into a full rx fifo is dropped unless a data read pops in the same cycle
  always @(posedge aclk)
  begin
    if (tx_push)
      tx_mem[tx_wp_ff] <= wdata_ff[7:0];
    if (rx_push_ff & (~rx_full | rx_pop))
      rx_mem[rx_wp_ff] <= rx_byte_ff;
    if (!aresetn)
    begin
      tx_wp_ff  <= {PTR_W{1'b0}};
      tx_rp_ff  <= {PTR_W{1'b0}};
      tx_cnt_ff <= {(PTR_W+1){1'b0}};
      rx_wp_ff  <= {PTR_W{1'b0}};
      rx_rp_ff  <= {PTR_W{1'b0}};
      rx_cnt_ff <= {(PTR_W+1){1'b0}};
    end
    else
    begin
      if (tx_push)
        tx_wp_ff <= tx_wp_ff + 1'b1;
      if (tx_pop)
        tx_rp_ff <= tx_rp_ff + 1'b1;
      tx_cnt_ff <= tx_cnt_ff + {{PTR_W{1'b0}}, tx_push} - {{PTR_W{1'b0}}, tx_pop};
      if (rx_push_ff & (~rx_full | rx_pop))
        rx_wp_ff <= rx_wp_ff + 1'b1;
      if (rx_pop)
        rx_rp_ff <= rx_rp_ff + 1'b1;
      rx_cnt_ff <= rx_cnt_ff + {{PTR_W{1'b0}}, rx_push_ff & (~rx_full | rx_pop)}
                   - {{PTR_W{1'b0}}, rx_pop};
    end
  end

  // command bits cleared when their sequence ends
  always @*
  begin
    cmd_clr = 4'h0;
    if (tick & (ph_ff[1:0] == 2'h3) & (st_ff == ST_START))
      cmd_clr[`SCI_CMD_START] = 1'b1;
    if (tick & (ph_ff[1:0] == 2'h2) & (st_ff == ST_STOP))
      cmd_clr[`SCI_CMD_STOP] = 1'b1;
    if (tick & (ph_ff[1:0] == 2'h2) & (st_ff == ST_BYTE) & (bit_ff == `SCI_I2C_LAST_BIT))
    begin
      cmd_clr[`SCI_CMD_SEND] = ~i2c_rx_ff;
      cmd_clr[`SCI_CMD_RECV] = i2c_rx_ff;
    end
  end

  // serial engines; the i2c pins only ever pull low
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff      <= ST_IDLE;
      ph_ff      <= 5'h00;
      bit_ff     <= 4'h0;
      div_ff     <= 20'h00000;
      sh_ff      <= 8'h00;
      rxs_ff     <= 8'h00;
      last_ff    <= 8'h00;
      i2c_rx_ff  <= 1'b0;
      rx_push_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
      ist_ff     <= 4'h0;
      spi_sck    <= 1'b0;
      spi_mosi   <= 1'b0;
      scl_o      <= 1'b0;
      scl_oe     <= 1'b0;
      sda_o      <= 1'b0;
      sda_oe     <= 1'b0;
    end
    else
    begin
      rx_push_ff <= 1'b0;
      div_ff     <= (idle | tick) ? 20'h00000 : div_ff + 20'h00001;
      if (idle & ~i2c_go)
        spi_sck <= cfg_ff[`SCI_CFG_POL];
      case (st_ff)
        ST_IDLE:
        begin
          ph_ff  <= 5'h00;
          bit_ff <= 4'h0;
          if (spi_go)
          begin
            st_ff   <= ST_SPI;
            sh_ff   <= load_byte;
            last_ff <= load_byte;
            if (!cpha)
              spi_mosi <= lsbf ? load_byte[0] : load_byte[7];
          end
          else if (i2c_go)
          begin
            ist_ff    <= 4'h0;
            i2c_rx_ff <= ~cmd_ff[`SCI_CMD_SEND];
            sh_ff     <= load_byte;
            if (cmd_ff[`SCI_CMD_STOP])
              st_ff <= ST_STOP;
            else if (cmd_ff[`SCI_CMD_START])
              st_ff <= ST_START;
            else
              st_ff <= ST_BYTE;
          end
        end
        ST_SPI:
        if (tick)
        begin
          spi_sck <= ~spi_sck;
          ph_ff   <= ph_ff + 5'h01;
          if (lead != cpha)
            rxs_ff <= rx_smp;
          else if (!cpha)
          begin
            sh_ff    <= sh_nxt;
            spi_mosi <= lsbf ? sh_nxt[0] : sh_nxt[7];
          end
          else
          begin
            spi_mosi <= outbit;
            sh_ff    <= sh_nxt;
          end
          if (ph_ff == `SCI_SPI_LAST_HALF)
          begin
            st_ff      <= ST_IDLE;
            rx_push_ff <= 1'b1;
            rx_byte_ff <= cpha ? rx_smp : rxs_ff;
          end
        end
        ST_START:
        if (tick)
        begin
          ph_ff <= ph_ff + 5'h01;
          case (ph_ff[1:0])
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            default:
            begin
              scl_oe                 <= 1'b1;
              st_ff                  <= ST_IDLE;
              ist_ff[`SCI_IST_CMDFIN] <= 1'b1;
            end
          endcase
        end
        ST_STOP:
        if (tick)
        begin
          ph_ff <= ph_ff + 5'h01;
          case (ph_ff[1:0])
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            default:
            begin
              sda_oe                 <= 1'b0;
              st_ff                  <= ST_IDLE;
              ist_ff[`SCI_IST_CMDFIN] <= 1'b1;
            end
          endcase
        end
        ST_BYTE:
        if (tick)
        begin
          ph_ff <= (ph_ff[1:0] == 2'h2) ? 5'h00 : ph_ff + 5'h01;
          case (ph_ff[1:0])
            2'h0:
            if (bit_ff == `SCI_I2C_LAST_BIT)
              sda_oe <= i2c_rx_ff & ack_ff;
            else
              sda_oe <= ~i2c_rx_ff & ~sh_ff[7];
            2'h1: scl_oe <= 1'b0;
            default:
            begin
              scl_oe <= 1'b1;
              bit_ff <= bit_ff + 4'h1;
              sh_ff  <= {sh_ff[6:0], 1'b0};
              if (bit_ff != `SCI_I2C_LAST_BIT)
                rxs_ff <= {rxs_ff[6:0], sda_i};
              else
              begin
                st_ff <= ST_IDLE;
                if (i2c_rx_ff)
                begin
                  rx_push_ff             <= 1'b1;
                  rx_byte_ff             <= rxs_ff;
                  ist_ff[`SCI_IST_RXFIN] <= 1'b1;
                end
                else
                begin
                  ist_ff[`SCI_IST_TXFIN] <= 1'b1;
                  ist_ff[`SCI_IST_NACK]  <= sda_i;
                end
              end
            end
          endcase
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
endmodule

// [dv/sci_serial_ctrl_props.sv]
// assertion checker on the register bus and serial pins of the controller
`timescale 1ns/1ps
module sci_serial_ctrl_props (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        spi_sck,
  input logic        scl_o,
  input logic        scl_oe,
  input logic        sda_o,
  input logic        sda_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // everything quiet on the first edge after reset
  property p_reset_quiet;
    $rose(aresetn) |-> !spi_sck && !scl_oe && !sda_oe && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins busy after reset");
  // open-drain lines only ever pull low
  property p_open_drain;
    !scl_o && !sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("bus line driven high");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write response not held");
  // a pending answer blocks the next request of the same kind
  property p_busy_refuse;
    (s_axi_bvalid |-> !s_axi_awready) and (s_axi_rvalid |-> !s_axi_arready);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("request taken while busy");
  // no register is wider than 16 bits
  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");

  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_sck: cover property ($rose(spi_sck));
  c_i2c: cover property ($rose(sda_oe) ##[1:40] $rose(scl_oe));
endmodule

// [dv/sci_slave_model.sv]
// behavioural spi loopback slave and i2c slave with bus pull-ups
`timescale 1ns/1ps
module sci_slave_model (
  input  logic       spi_sck,
  input  logic       spi_mosi,
  output logic       spi_miso,
  input  logic       cpol,
  input  logic       cpha,
  input  logic       scl_oe,
  input  logic       sda_oe,
  input  logic       slv_ack,
  output logic       scl_i,
  output logic       sda_i,
  output logic [7:0] spi_byte,
  output logic [7:0] i2c_byte,
  output logic       i2c_ack_bit
);
  reg [3:0] bits = 4'h0;
  reg [7:0] sh;
  reg       pull = 1'b0;
  // loopback so the byte read equals the byte sent in every mode
  assign spi_miso = spi_mosi;
  // pull-ups, and this slave never stretches the clock
  assign scl_i = !scl_oe;
  assign sda_i = !(sda_oe || pull);
  // capture mosi on the edge where the master samples
  always @(spi_sck)
    if (spi_sck == (cpol == cpha))
      spi_byte <= {spi_byte[6:0], spi_mosi};
  // start condition restarts the bit count
  always @(negedge sda_i)
    if (scl_i)
      bits <= 4'h0;
  // eight data bits then the acknowledge bit
  always @(posedge scl_i)
  begin
    if (bits == 4'h8)
      i2c_byte <= sh;
    if (bits == 4'h8)
      i2c_ack_bit <= sda_i;
    else
      sh <= {sh[6:0], sda_i};
    bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
  end
  // pull sda low through the ninth clock when acking
  always @(negedge scl_i)
    pull <= slv_ack && bits == 4'h8;
endmodule

// [dv/sci_serial_ctrl_tb.sv]
// self-checking bench: registers, spi loopback in all modes, i2c commands
`timescale 1ns/1ps
`include "sci_map.vh"
module sci_serial_ctrl_tb;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        cpol, cpha, slv_ack;
  logic [7:0]  b;
  logic [1:0]  rsp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         spi_sck, spi_mosi, spi_miso, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, i2c_ack_bit;
  wire [7:0]   spi_byte, i2c_byte;
  int          bad_count, comparisons;
  logic        sck_was;
  int          cyc;

  sci_serial_ctrl dut (.*);
  sci_slave_model u_slv (.*);

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a spent wait bound ends the run as a failure
  task automatic give_up(input int n);
    if (n >= 3000)
    begin
      bad_count++;
      conclude();
    end
  endtask

  // each channel is released on the edge its ready is seen
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 3000);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    give_up(n);
  endtask

  task automatic rdr(input logic [15:0] idx);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 3000);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    give_up(n);
  endtask

  task automatic poll(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    rdr(idx);
    while ((rd & m) !== v && n < 3000)
    begin
      rdr(idx);
      n++;
    end
    give_up(n);
  endtask

  // wait for the shifter, then read out every byte expecting e
  task automatic drain(input logic [7:0] e);
    int n;
    n = 0;
    poll(`SCI_IDX_SPI_STAT, 32'h8, 32'h8);
    rdr(`SCI_IDX_SPI_STAT);
    while (rd[1] === 1'b1 && n < 8)
    begin
      rdr(`SCI_IDX_DATA);
      check("rx byte", rd, {24'h0, e});
      rdr(`SCI_IDX_SPI_STAT);
      n++;
    end
    check("drained status", rd, 32'hc);
  endtask

  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int i = 0; i < 8; i++)
      rev[i] = x[7 - i];
  endfunction

  initial
  begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, cpol, cpha, slv_ack} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, reserved bits, unmapped address
    rdr(`SCI_IDX_SPI_STAT);
    check("status reset", rd, 32'hc);
    wr(`SCI_IDX_I2C_ACK, 32'hffff);
    rdr(`SCI_IDX_I2C_ACK);
    check("ack reserved", rd, 32'h1);
    wr(`SCI_IDX_SPI_CFG, 32'hffc0);
    rdr(`SCI_IDX_SPI_CFG);
    check("cfg reserved", rd, 32'h0);
    s_axi_wstrb <= 4'he;
    wr(`SCI_IDX_SPI_CFG, 32'h10);
    s_axi_wstrb <= 4'hf;
    rdr(`SCI_IDX_SPI_CFG);
    check("strobe off", rd, 32'h0);
    wr(16'h4400, 32'h0);
    check("unmapped bresp", rsp, `SCI_RESP_SLVERR);
    $display("register test done");
    // every polarity, phase and order; master select kept set
    wr(`SCI_IDX_RATE_LIN, 32'h3);
    for (int k = 0; k < 8; k++)
    begin
      cpol = k[0];
      cpha = k[1];
      b = 8'h96 ^ k[7:0];
      wr(`SCI_IDX_SPI_CFG, 32'h10 | k);
      wr(`SCI_IDX_DATA, {24'h0, b});
      poll(`SCI_IDX_SPI_STAT, 32'h2, 32'h2);
      rdr(`SCI_IDX_DATA);
      check("loopback", rd, {24'h0, b});
      check("wire order", spi_byte, k[2] ? rev(b) : b);
      check("sck idle", spi_sck, k[0]);
    end
    // one half bit lasts (lin+1)<<exp clocks, timed between two sck toggles
    wr(`SCI_IDX_RATE_EXP, 32'h1);
    wr(`SCI_IDX_DATA, 32'h5a);
    for (int h = 0; h < 2; h++)
    begin
      sck_was = spi_sck;
      cyc = 0;
      while (spi_sck === sck_was && cyc < 3000)
      begin
        @(posedge aclk);
        cyc++;
      end
      give_up(cyc);
    end
    check("half bit", cyc, 8);
    drain(8'h5a);
    wr(`SCI_IDX_RATE_EXP, 32'h0);
    // five bytes into a four-deep receive path, none read yet
    for (int k = 0; k < 5; k++)
      wr(`SCI_IDX_DATA, 32'h40 + k);
    rdr(`SCI_IDX_SPI_STAT);
    check("tx space", rd[2], 1'b0);
    poll(`SCI_IDX_SPI_STAT, 32'h8, 32'h8);
    rdr(`SCI_IDX_SPI_STAT);
    check("overrun", rd[0], 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      rdr(`SCI_IDX_DATA);
      check("rx order", rd, 32'h40 + k);
    end
    rdr(`SCI_IDX_SPI_STAT);
    check("overrun cleared", rd, 32'hc);
    // receiver-driven runs on an empty transmit path, token then repeat
    wr(`SCI_IDX_SPI_CFG, 32'h30);
    poll(`SCI_IDX_SPI_STAT, 32'h2, 32'h2);
    wr(`SCI_IDX_SPI_CFG, 32'h10);
    drain(8'hff);
    wr(`SCI_IDX_SPI_CFG, 32'h18);
    wr(`SCI_IDX_DATA, 32'h3c);
    drain(8'h3c);
    wr(`SCI_IDX_SPI_CFG, 32'h38);
    poll(`SCI_IDX_SPI_STAT, 32'h2, 32'h2);
    wr(`SCI_IDX_SPI_CFG, 32'h18);
    drain(8'h3c);
    $display("spi test done");
    // i2c: one command at a time, each waited out
    wr(`SCI_IDX_MODE, 32'h1);
    wr(`SCI_IDX_I2C_CMD, 32'h4);
    poll(`SCI_IDX_I2C_CMD, 32'hf, 32'h0);
    rdr(`SCI_IDX_I2C_STAT);
    check("start done", rd, 32'h8);
    for (int k = 0; k < 2; k++)
    begin
      slv_ack = !k[0];
      wr(`SCI_IDX_DATA, 32'ha6);
      wr(`SCI_IDX_I2C_CMD, 32'h2);
      poll(`SCI_IDX_I2C_CMD, 32'hf, 32'h0);
      check("i2c byte", i2c_byte, 8'ha6);
      rdr(`SCI_IDX_I2C_STAT);
      check("send status", rd, 32'h2 | k);
    end
    slv_ack = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      wr(`SCI_IDX_I2C_ACK, 32'h1 ^ k);
      wr(`SCI_IDX_I2C_CMD, 32'h1);
      poll(`SCI_IDX_I2C_CMD, 32'hf, 32'h0);
      check("master ack", i2c_ack_bit, k[0]);
      rdr(`SCI_IDX_I2C_STAT);
      check("recv status", rd, 32'h4);
      rdr(`SCI_IDX_DATA);
      check("i2c rx", rd, 32'hff);
    end
    wr(`SCI_IDX_I2C_CMD, 32'h8);
    poll(`SCI_IDX_I2C_CMD, 32'hf, 32'h0);
    rdr(`SCI_IDX_I2C_STAT);
    check("stop done", rd, 32'h8);
    check("bus free", {scl_i, sda_i}, 2'h3);
    $display("i2c test done");
    conclude();
  end
endmodule

bind sci_serial_ctrl sci_serial_ctrl_props u_props (.*);
